//--- verilog/jad_pkg.sv
// Shared constants and types for the jack accessory detection block.
// Assumes a single 10 MHz clock and an APB slave with 32-bit data.
package jad_pkg;
    // Register indexes; the byte address is four times the index.
    localparam logic [7:0] IDX_THR_1 = 8'hC8;
    localparam logic [7:0] IDX_THR_2 = 8'hC9;
    localparam logic [7:0] IDX_THR_3 = 8'hCA;
    localparam logic [7:0] IDX_THR_TOP = 8'hCB;
    localparam logic [7:0] IDX_FORCE = 8'hCC;
    localparam logic [7:0] IDX_HPTEST = 8'hCD;
    localparam logic [7:0] IDX_CTRL = 8'hCE;
    localparam logic [7:0] IDX_RESULT = 8'hCF;
    localparam logic [7:0] IDX_INT_STAT = 8'hD0;
    localparam logic [7:0] IDX_INT_MASK = 8'hD1;
    // Reset values.
    localparam logic [7:0] RST_THR_1 = 8'h0A;
    localparam logic [7:0] RST_THR_2 = 8'h16;
    localparam logic [7:0] RST_THR_3 = 8'h21;
    localparam logic [7:0] RST_THR_TOP = 8'h3E;
    localparam logic [7:0] RST_FORCE = 8'h01;
    localparam logic [7:0] RST_HPTEST = 8'h02;
    localparam logic [7:0] RST_CTRL = 8'h06;
    // Field positions.
    localparam int FORCE_TYPE_BIT = 5;
    localparam int FORCE_ORDER_BIT = 4;
    localparam int REPEAT_LSB = 2;
    localparam int AVG_LSB = 0;
    localparam int HP_COMP_BIT = 4;
    localparam int HP_SEL_LSB = 1;
    localparam int HP_EN_BIT = 0;
    localparam int CTRL_PAUSE_BIT = 0;
    localparam int CTRL_TYPE_DET_BIT = 1;
    localparam int CTRL_ORDER_DET_BIT = 2;
    localparam int INT_BUTTON = 0;
    localparam int INT_HPCOMP = 1;
    localparam int INT_JACK = 2;
    localparam int INT_W = 3;
    // Timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int CHECK_TIME_NS = 100_000;
    localparam int CHECK_CYCLES = CHECK_TIME_NS / CLK_PERIOD_NS;
    localparam int AVG_STEP_TIME_NS = 1_000_000;
    localparam int AVG_STEP_CYCLES = AVG_STEP_TIME_NS / CLK_PERIOD_NS;
    // Button result codes, lowest impedance first.
    typedef enum logic [2:0] {
        BTN_NONE = 3'h0,
        BTN_1 = 3'h1,
        BTN_2 = 3'h2,
        BTN_3 = 3'h3,
        BTN_4 = 3'h4
    } jad_button_type;
    // Measurement sequencer states, Gray from ST_IDLE through ST_CHECK and ST_AVERAGE to ST_DONE.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CHECK = 2'h1,
        ST_AVERAGE = 2'h3,
        ST_DONE = 2'h2
    } jad_state_type;
endpackage : jad_pkg

//--- verilog/jad_meas_if.sv
// Interface between the register block and the measurement sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface jad_meas_if;
    logic run;
    logic [1:0] repeat_sel;
    logic [1:0] avg_sel;
    logic result_valid;
    logic [7:0] avg_code;
    modport ctrl (output run, repeat_sel, avg_sel, input result_valid, avg_code);
    modport seq (input run, repeat_sel, avg_sel, output result_valid, avg_code);
endinterface : jad_meas_if
`default_nettype wire

//--- verilog/jad_classify.sv
// Button classifier: maps an averaged impedance code to a button.
// Assumes thresholds are programmed in ascending order.
`timescale 1ns/10ps
`default_nettype none
module jad_classify (
    input wire logic [7:0] code, // Averaged impedance code.
    input wire logic [7:0] thr_1, // Lowest threshold.
    input wire logic [7:0] thr_2, // Second threshold.
    input wire logic [7:0] thr_3, // Third threshold.
    input wire logic [7:0] thr_top, // Button to microphone threshold.
    output var jad_pkg::jad_button_type button // Classified button.
);
    import jad_pkg::*;

    // First threshold that the code sits under wins.
    always_comb begin
        if (code < thr_1) begin
            button = BTN_1;
        end else if (code < thr_2) begin
            button = BTN_2;
        end else if (code < thr_3) begin
            button = BTN_3;
        end else if (code < thr_top) begin
            button = BTN_4;
        end else begin
            button = BTN_NONE;
        end
    end
endmodule : jad_classify
`default_nettype wire

//--- verilog/jad_meas_seq.sv
// Periodic button check: repeated 1-bit checks, then averaged 8-bit codes.
// Assumes press_level is already synchronised and adc_code is on this clock.
`timescale 1ns/10ps
`default_nettype none
module jad_meas_seq #(
    parameter int STEP_CYCLES = jad_pkg::AVG_STEP_CYCLES
) (
    input wire logic clock, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic press_level, // Button press comparator, synchronised.
    input wire logic [7:0] adc_code, // Live 8-bit impedance code.
    jad_meas_if.seq m // Settings in, result out.
);
    import jad_pkg::*;

    jad_state_type state_q;
    logic [15:0] cnt_q;
    logic [3:0] hits_q;
    logic [10:0] sum_q;
    logic [10:0] sum_d;
    logic [3:0] rep_target;
    logic [3:0] avg_target;
    logic last_check;
    logic last_step;

    assign rep_target = 4'h1 << m.repeat_sel;
    assign avg_target = 4'h1 << m.avg_sel;
    assign sum_d = sum_q + {3'h0, adc_code};
    assign last_check = (cnt_q == 16'(CHECK_CYCLES - 1));
    assign last_step = (cnt_q == 16'(STEP_CYCLES - 1));

    // One sequencer; dropping run stops checking at once.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            hits_q <= 4'h0;
            sum_q <= 11'h000;
            m.avg_code <= 8'h00;
            m.result_valid <= 1'b0;
        end else begin
            m.result_valid <= 1'b0;
            cnt_q <= cnt_q + 16'h0001;
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 16'h0000;
                    hits_q <= 4'h0;
                    if (m.run) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (!m.run) begin
                        state_q <= ST_IDLE;
                    end else if (last_check) begin
                        cnt_q <= 16'h0000;
                        sum_q <= 11'h000;
                        if (!press_level) begin
                            hits_q <= 4'h0;
                        end else if (hits_q + 4'h1 == rep_target) begin
                            hits_q <= 4'h0;
                            state_q <= ST_AVERAGE;
                        end else begin
                            hits_q <= hits_q + 4'h1;
                        end
                    end
                end
                ST_AVERAGE: begin
                    if (!m.run) begin
                        state_q <= ST_IDLE;
                    end else if (last_step) begin
                        cnt_q <= 16'h0000;
                        sum_q <= sum_d;
                        hits_q <= hits_q + 4'h1;
                        if (hits_q + 4'h1 == avg_target) begin
                            m.avg_code <= 8'(sum_d >> m.avg_sel);
                            m.result_valid <= 1'b1;
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // Wait for release so one press gives one result.
                    cnt_q <= 16'h0000;
                    hits_q <= 4'h0;
                    if (!m.run) begin
                        state_q <= ST_IDLE;
                    end else if (!press_level) begin
                        state_q <= ST_CHECK;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Helper: cycles spent averaging, held through the result cycle.
    int dur_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dur_q <= 0;
        end else if (state_q == ST_AVERAGE) begin
            dur_q <= dur_q + 1;
        end else if (state_q != ST_DONE) begin
            dur_q <= 0;
        end
    end

    sequence s_stopped;
        !m.run ##1 !m.run;
    endsequence

    a_pause_no_result: assert property (@(posedge clock) disable iff (!resetn)
        s_stopped |-> !m.result_valid && state_q == ST_IDLE)
        else $error("Result or activity while checking is stopped.");
    a_repeat_count: assert property (@(posedge clock) disable iff (!resetn)
        $rose(state_q == ST_AVERAGE) |-> $past(hits_q) + 4'h1 == $past(rep_target))
        else $error("Averaging began after the wrong number of checks.");
    a_avg_latency: assert property (@(posedge clock) disable iff (!resetn)
        m.result_valid |-> dur_q == int'(avg_target) * STEP_CYCLES)
        else $error("Averaging latency is not one step per measurement.");
endmodule : jad_meas_seq
`default_nettype wire

//--- verilog/jad_accessory_detect.sv
// Jack accessory detection: configuration registers, button result, jack
// type and pin order selection, headphone load test and interrupt.
// Assumes an APB master on the same clock; analog pins are asynchronous.
//
// What this block does
// - Codes under the top limit but above the third threshold give the top button.
// - With type detection off, force bit picks three or four contacts.
// - With order detection off, force bit picks ground-first or mic-first on a four-contact jack.
// - Two-bit field sets one, two, four or eight 1-bit checks.
// - Two-bit field sets one, two, four or eight averaged codes.
// - Each extra averaged code adds about one millisecond.
// - Comparator bit reads 1 when load is under the selected threshold.
// - Two-bit field selects 1000, 2500, 5000 or 10000 ohm.
// - Headphone test runs only while its enable bit is set.
// - Thresholds ascend; under the first is the lowest button.
// - Pause stops button checking; jack changes still reported.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module jad_accessory_detect #(
    parameter int AVG_STEP = jad_pkg::AVG_STEP_CYCLES
) (
    input wire logic clock, // 10 MHz clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic jack_present_pin, // Jack inserted, asynchronous.
    input wire logic button_press_pin, // 1-bit press comparator, asynchronous.
    input wire logic hp_comp_pin, // Headphone load comparator, asynchronous.
    input wire logic [7:0] adc_code, // 8-bit impedance code, same clock.
    input wire logic auto_four_pole, // Detected jack type, same clock.
    input wire logic auto_mic_first, // Detected pin order, same clock.
    output logic irq, // Interrupt, active high level.
    output logic jack_four_pole, // Jack type in use.
    output logic mic_before_ground_order, // Pin order in use.
    output logic hp_test_enable, // Headphone test block enable.
    output logic [1:0] hp_test_sel // Headphone test threshold select.
);
    import jad_pkg::*;

    jad_meas_if m ();

    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic jack_sync;
    logic press_sync;
    logic hp_sync;

    logic [7:0] thr_1_q;
    logic [7:0] thr_2_q;
    logic [7:0] thr_3_q;
    logic [7:0] thr_top_q;
    logic [7:0] force_q;
    logic [7:0] hptest_q;
    logic [7:0] ctrl_q;
    logic [INT_W-1:0] int_stat_q;
    logic [INT_W-1:0] int_stat_d;
    logic [INT_W-1:0] int_mask_q;
    logic [INT_W-1:0] events;

    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [7:0] idx;
    logic addr_ok;
    logic done;
    logic wr_en;
    logic stat_read;

    jad_button_type btn_d;
    jad_button_type btn_q;
    logic [7:0] avg_q;
    logic hp_comp_q;
    logic jack_prev_q;
    logic irq_q;
    logic four_pole_q;
    logic mic_first_q;
    logic four_pole_d;

    // Two flip-flops per pin before anything looks at the level.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    pin_meta_q[gi] <= 1'b0;
                    pin_sync_q[gi] <= 1'b0;
                end else begin
                    pin_meta_q[gi] <= gi == 0 ? jack_present_pin :
                        gi == 1 ? button_press_pin : hp_comp_pin;
                    pin_sync_q[gi] <= pin_meta_q[gi];
                end
            end
        end
    endgenerate

    assign jack_sync = pin_sync_q[0];
    assign press_sync = pin_sync_q[1];
    assign hp_sync = pin_sync_q[2];

    // Address decode: one aligned word per register.
    assign idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign done = psel && penable && pready_q;
    assign wr_en = done && pwrite && addr_ok;
    assign stat_read = done && !pwrite && addr_ok && idx == IDX_INT_STAT;

    // APB handshake: every access phase lasts two cycles.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !(addr_ok && rd_hit);
            if (psel && penable && !pready_q) begin
                prdata_q <= (addr_ok && !pwrite) ? rd_data : 32'h0000_0000;
            end
        end
    end

    // Software-written registers.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            thr_1_q <= RST_THR_1;
            thr_2_q <= RST_THR_2;
            thr_3_q <= RST_THR_3;
            thr_top_q <= RST_THR_TOP;
            force_q <= RST_FORCE;
            hptest_q <= RST_HPTEST;
            ctrl_q <= RST_CTRL;
            int_mask_q <= '0;
        end else if (wr_en) begin
            case (idx)
                IDX_THR_1: thr_1_q <= pwdata[7:0];
                IDX_THR_2: thr_2_q <= pwdata[7:0];
                IDX_THR_3: thr_3_q <= pwdata[7:0];
                IDX_THR_TOP: thr_top_q <= pwdata[7:0];
                IDX_FORCE: force_q <= {2'h0, pwdata[5:0]};
                // The comparator bit is read only and never stored.
                IDX_HPTEST: hptest_q <= {5'h00, pwdata[2:0]};
                IDX_CTRL: ctrl_q <= {5'h00, pwdata[2:0]};
                IDX_INT_MASK: int_mask_q <= pwdata[INT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read multiplexer; unmapped words read zero and raise pslverr.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (idx)
            IDX_THR_1: rd_data[7:0] = thr_1_q;
            IDX_THR_2: rd_data[7:0] = thr_2_q;
            IDX_THR_3: rd_data[7:0] = thr_3_q;
            IDX_THR_TOP: rd_data[7:0] = thr_top_q;
            IDX_FORCE: rd_data[7:0] = force_q;
            IDX_HPTEST: begin
                rd_data[7:0] = hptest_q;
                rd_data[HP_COMP_BIT] = hp_comp_q;
            end
            IDX_CTRL: rd_data[7:0] = ctrl_q;
            IDX_RESULT: rd_data[15:0] = {avg_q, 5'h00, btn_q};
            IDX_INT_STAT: rd_data[INT_W-1:0] = int_stat_q;
            IDX_INT_MASK: rd_data[INT_W-1:0] = int_mask_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // Settings to the sequencer; pause or no jack stops checking.
    assign m.run = jack_sync && !ctrl_q[CTRL_PAUSE_BIT];
    assign m.repeat_sel = force_q[REPEAT_LSB+1:REPEAT_LSB];
    assign m.avg_sel = force_q[AVG_LSB+1:AVG_LSB];

    jad_meas_seq #(
        .STEP_CYCLES(AVG_STEP)
    ) u_seq (
        .clock(clock),
        .resetn(resetn),
        .press_level(press_sync),
        .adc_code(adc_code),
        .m(m)
    );

    jad_classify u_classify (
        .code(m.avg_code),
        .thr_1(thr_1_q),
        .thr_2(thr_2_q),
        .thr_3(thr_3_q),
        .thr_top(thr_top_q),
        .button(btn_d)
    );

    // Latch the classified button with its averaged code.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            btn_q <= BTN_NONE;
            avg_q <= 8'h00;
        end else if (m.result_valid) begin
            btn_q <= btn_d;
            avg_q <= m.avg_code;
        end
    end

    // Comparator result is forced low while the test is disabled.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hp_comp_q <= 1'b0;
        end else begin
            hp_comp_q <= hptest_q[HP_EN_BIT] && hp_sync;
        end
    end

    // Events: new button result, comparator change, jack change.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            jack_prev_q <= 1'b0;
        end else begin
            jack_prev_q <= jack_sync;
        end
    end

    always_comb begin
        events = '0;
        events[INT_BUTTON] = m.result_valid;
        events[INT_HPCOMP] = hp_comp_q != (hptest_q[HP_EN_BIT] && hp_sync);
        events[INT_JACK] = jack_prev_q != jack_sync;
    end

    // A set in the clearing cycle wins; an event one cycle before the clear is cleared unread.
    assign int_stat_d = (int_stat_q & ~(stat_read ? {INT_W{1'b1}} : {INT_W{1'b0}}))
        | events;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            int_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    // Jack type and pin order: detector result or software force.
    assign four_pole_d = ctrl_q[CTRL_TYPE_DET_BIT] ? auto_four_pole
        : force_q[FORCE_TYPE_BIT];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            four_pole_q <= 1'b0;
            mic_first_q <= 1'b0;
        end else begin
            four_pole_q <= four_pole_d;
            // Order only means something on a four-contact jack.
            if (!four_pole_d) begin
                mic_first_q <= 1'b0;
            end else if (ctrl_q[CTRL_ORDER_DET_BIT]) begin
                mic_first_q <= auto_mic_first;
            end else begin
                mic_first_q <= force_q[FORCE_ORDER_BIT];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign jack_four_pole = four_pole_q;
    assign mic_before_ground_order = mic_first_q;
    assign hp_test_enable = hptest_q[HP_EN_BIT];
    assign hp_test_sel = hptest_q[HP_SEL_LSB+1:HP_SEL_LSB];

    sequence s_access;
        psel && penable && !pready_q;
    endsequence

    // Bus, classification, forcing, headphone test and interrupt checks.
    a_apb_ready: assert property (@(posedge clock) disable iff (!resetn)
        s_access |=> pready_q)
        else $error("Access phase not answered in one cycle.");

    a_top_button: assert property (@(posedge clock) disable iff (!resetn)
        m.result_valid && m.avg_code < thr_top_q && m.avg_code >= thr_3_q
        && thr_3_q >= thr_2_q && thr_2_q >= thr_1_q
        |=> btn_q == BTN_4)
        else $error("Code under top limit not reported as top button.");

    a_lowest_button: assert property (@(posedge clock) disable iff (!resetn)
        m.result_valid && m.avg_code < thr_1_q |=> btn_q == BTN_1)
        else $error("Code under first threshold not lowest button.");

    a_mic_only: assert property (@(posedge clock) disable iff (!resetn)
        m.result_valid && m.avg_code >= thr_top_q |=> btn_q == BTN_NONE)
        else $error("Code at or above top limit reported as a button.");

    a_type_force: assert property (@(posedge clock) disable iff (!resetn)
        !ctrl_q[CTRL_TYPE_DET_BIT] |=> four_pole_q == $past(force_q[FORCE_TYPE_BIT]))
        else $error("Forced jack type not applied.");

    a_order_force: assert property (@(posedge clock) disable iff (!resetn)
        !ctrl_q[CTRL_TYPE_DET_BIT] && !ctrl_q[CTRL_ORDER_DET_BIT]
        |=> mic_first_q == ($past(force_q[FORCE_TYPE_BIT]) && $past(force_q[FORCE_ORDER_BIT])))
        else $error("Forced pin order not applied.");

    a_hp_disabled: assert property (@(posedge clock) disable iff (!resetn)
        !hptest_q[HP_EN_BIT] [*2] |-> !hp_comp_q)
        else $error("Comparator result shown while test disabled.");

    a_hp_compare: assert property (@(posedge clock) disable iff (!resetn)
        hptest_q[HP_EN_BIT] ##1 hptest_q[HP_EN_BIT] |-> hp_comp_q == $past(hp_sync))
        else $error("Comparator result lost while test enabled.");

    a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
        |(int_stat_q & int_mask_q) |=> irq_q)
        else $error("Unmasked status did not raise the interrupt.");

    a_irq_quiet: assert property (@(posedge clock) disable iff (!resetn)
        !(|(int_stat_q & int_mask_q))
        |=> !irq_q)
        else $error("Interrupt high with no unmasked status.");

    // Status holds until read; a read keeps only its own cycle's events.
    a_stat_sticky: assert property (@(posedge clock) disable iff (!resetn)
        !stat_read |=> (int_stat_q & $past(int_stat_q)) == $past(int_stat_q))
        else $error("Status bit lost without a read.");

    a_read_clear: assert property (@(posedge clock) disable iff (!resetn)
        stat_read |=> (int_stat_q & ~$past(events)) == '0)
        else $error("Status read did not clear.");
endmodule : jad_accessory_detect
`default_nettype wire

//--- test/jad_accessory_model.sv
// Accessory model: jack contact, button press and headphone load.
// Assumes the bench sets its controls after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module jad_accessory_model (
    input wire logic plugged, // Jack inserted.
    input wire logic press, // Button held.
    input wire logic [7:0] code, // Press impedance code.
    input wire logic [15:0] load, // Load in ohm.
    input wire logic en, // Test block on.
    input wire logic [1:0] sel, // Test threshold.
    output logic jack_pin, // Jack contact.
    output logic press_pin, // Press comparator.
    output logic comp_pin, // Load comparator.
    output logic [7:0] adc // Impedance code.
);
    logic [15:0] lim;
    // Comparator answers only while enabled; open mic reads full scale.
    always_comb begin
        lim = sel[1] ? (sel[0] ? 16'h2710 : 16'h1388) : (sel[0] ? 16'h09C4 : 16'h03E8);
        comp_pin = en & (load < lim);
        jack_pin = plugged;
        press_pin = plugged & press;
        adc = press_pin ? code : 8'hFF;
    end
endmodule : jad_accessory_model
`default_nettype wire

//--- test/jad_accessory_detect_tb.sv
// Bench for jack accessory detection through APB calls.
// Assumes AVG_STEP is shortened to 20 cycles.
`timescale 1ns/10ps
`default_nettype none
module jad_accessory_detect_tb;
    import jad_pkg::*;
    logic clock, resetn, psel, penable, pwrite, pready, pslverr, irq, four, mg, en;
    logic plugged, press, jp, pp, cp, af, am;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] code, adc, c;
    logic [1:0] sel;
    int mismatches, checked, lat;
    jad_accessory_detect #(.AVG_STEP(20)) DUT (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .jack_present_pin(jp), .button_press_pin(pp),
        .hp_comp_pin(cp), .adc_code(adc), .auto_four_pole(af), .auto_mic_first(am), .irq(irq),
        .jack_four_pole(four), .mic_before_ground_order(mg), .hp_test_enable(en), .hp_test_sel(sel));
    jad_accessory_model model (.plugged(plugged), .press(press), .code(code), .load(16'h0BB8),
        .en(en), .sel(sel), .jack_pin(jp), .press_pin(pp), .comp_pin(cp), .adc(adc));
    // Clock at 10 MHz.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // One transfer; data and error are taken at the pready edge, then a spare edge.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic err);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, 2'h0, idx, 2'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        chk("pslverr", {pready, pslverr}, {1'b1, err});
        {psel, penable} <= 2'h0;
        @(posedge clock);
    endtask : apb
    // Hold a press until the result interrupt, read result and status, release.
    task automatic push(input logic [7:0] v, input logic [2:0] b);
        {code, press} <= {v, 1'b1};
        lat = 0;
        while (irq !== 1'b1 && lat < 12000) begin
            @(posedge clock);
            lat++;
        end
        apb(1'b0, IDX_RESULT, 32'h0, 1'b0);
        chk("result", rd, {16'h0, v, 5'h0, b});
        apb(1'b0, IDX_INT_STAT, 32'h0, 1'b0);
        chk("status", rd, 32'h1);
        press <= 1'b0;
        repeat (2100) @(posedge clock);
        chk("irq clear", irq, 1'b0);
    endtask : push
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    // Watchdog sized well past the expected run of some 40000 cycles.
    initial begin
        repeat (70000) @(posedge clock);
        mismatches++;
        stop_test();
    end
    initial begin
        {resetn, psel, penable, pwrite, plugged, press, af, am, paddr, pwdata, code} = '0;
        mismatches = 0;
        checked = 0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        plugged <= 1'b1;
        apb(1'b0, IDX_THR_TOP, 32'h0, 1'b0);
        chk("top", rd, 32'h3E);
        apb(1'b0, IDX_FORCE, 32'h0, 1'b0);
        chk("force", rd, 32'h1);
        apb(1'b0, IDX_HPTEST, 32'h0, 1'b0);
        chk("hptest", {rd, en, sel}, {32'h2, 3'h1});
        apb(1'b0, 8'hD2, 32'h0, 1'b1);
        chk("unmapped", rd, 32'h0);
        apb(1'b0, IDX_INT_STAT, 32'h0, 1'b0);
        chk("jack event", {rd, irq}, {32'h4, 1'b0});
        $display("registers done");
        // Forced type and order with detection off, then automatic.
        apb(1'b1, IDX_CTRL, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, IDX_FORCE, {26'h0, i[1:0], 4'h1}, 1'b0);
            @(posedge clock);
            chk("forced", {four, mg}, {i[1], i[1] & i[0]});
        end
        {af, am} <= 2'h3;
        apb(1'b1, IDX_CTRL, 32'h6, 1'b0);
        repeat (2) @(posedge clock);
        chk("auto", {four, mg}, 2'h3);
        $display("jack done");
        apb(1'b1, IDX_THR_3, (256 * 325 + 1262) / 2525, 1'b0);
        apb(1'b1, IDX_INT_MASK, 32'h1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            c = i[0] ? (8'h0A << (i / 2)) - 8'h1 : 8'h0A << (i / 2);
            push(c, c < 8'h0A ? 3'h1 : c < 8'h16 ? 3'h2 : c < 8'h21 ? 3'h3 : c < 8'h3E ? 3'h4 : 3'h0);
        end
        push(8'h3D, 3'h4);
        push(8'h3E, 3'h0);
        push(8'h20, 3'h3);
        apb(1'b1, IDX_FORCE, 32'h0F, 1'b0);
        push(8'h30, 3'h4);
        chk("slow", lat >= 7160 && lat <= 8200, 1);
        apb(1'b1, IDX_FORCE, 32'h0, 1'b0);
        push(8'h30, 3'h4);
        chk("fast", lat >= 20 && lat <= 1040, 1);
        $display("button done");
        apb(1'b1, IDX_INT_MASK, 32'h5, 1'b0);
        apb(1'b1, IDX_CTRL, 32'h7, 1'b0);
        {code, press} <= {8'h30, 1'b1};
        repeat (3000) @(posedge clock);
        chk("paused", irq, 1'b0);
        plugged <= 1'b0;
        repeat (10) @(posedge clock);
        apb(1'b0, IDX_INT_STAT, 32'h0, 1'b0);
        chk("removal", rd, 32'h4);
        $display("pause done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, IDX_HPTEST, {29'h0, i[1:0], i < 4}, 1'b0);
            repeat (5) @(posedge clock);
            apb(1'b0, IDX_HPTEST, 32'h0, 1'b0);
            chk("hp", {rd, en, sel}, {27'h0, i[1] & i < 4, 1'b0, i[1:0], i < 4, i < 4, i[1:0]});
        end
        $display("hp test done");
        stop_test();
    end
endmodule : jad_accessory_detect_tb
`default_nettype wire
